// ==== design/dpw_ram.sv ====
// Dual-port RAM whose array write triggers on the rising or falling edge.
// Assumes both ports and the read logic share clk_i; reads are either
// continuous or taken on the rising edge, chosen at elaboration.
`timescale 1ns/100ps

// What this block does
// R1: Default style: rising write, continuous read output.
// R2: Emulation style: falling write, rising-edge read.
// R3: Rising mode stores data at request edge.
// R4: Falling mode captures on rise, commits next fall.
// R5: Address and data always latched on rising edge.
// R6: Continuous read shows completed write without clock.
// R7: Same-address writes together make word unknown.
// R8: Later clean write replaces unknown word.
// R9: User keeps same-address writes apart in time.
// R10: Read-only build has no write path.
// R11: Different-address simultaneous writes both succeed.
module dpw_ram #(
  parameter dpw_pkg::dpw_edge_e WR_EDGE   = dpw_pkg::DPW_WR_RISE,
  parameter bit                 RD_CONT   = 1'b1,
  parameter bit                 READ_ONLY = 1'b0,
  parameter int                 DEPTH     = dpw_pkg::DEPTH
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire dpw_pkg::dpw_req_s port_a_i,
  input  wire dpw_pkg::dpw_req_s port_b_i,
  output dpw_pkg::dpw_rsp_s      rsp_a_o,
  output dpw_pkg::dpw_rsp_s      rsp_b_o
);
  import dpw_pkg::*;

  // ==========================================================================
  // Elaboration checks.
  // Refused at elaboration, so a bad depth never reaches simulation.
  if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("DEPTH must lie between 2 and the address range");
  end

  // ==========================================================================
  // Storage and captured requests.
  logic [DATA_W-1:0] mem   [DEPTH];
  logic              bad_r [DEPTH];
  dpw_req_s          cap_a;
  dpw_req_s          cap_b;
  logic              cap_we_a;
  logic              cap_we_b;

  dpw_cap u_cap_a (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .req_i (port_a_i),
    .we_o  (cap_we_a),
    .cap_o (cap_a)
  );

  dpw_cap u_cap_b (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .req_i (port_b_i),
    .we_o  (cap_we_b),
    .cap_o (cap_b)
  );

  // Two writes to one word in the same write cycle contend.
  function automatic logic clash(input dpw_req_s a, input dpw_req_s b);
    return a.we && b.we && (a.addr == b.addr);
  endfunction : clash

  // ==========================================================================
  // Write selection.
  // Rising mode commits the live request at its own edge; falling mode
  // commits the request captured at the preceding rising edge.
  dpw_req_s wr_a;
  dpw_req_s wr_b;
  logic     wr_en_a;
  logic     wr_en_b;
  logic     wr_clash;

  assign wr_a     = (WR_EDGE == DPW_WR_RISE) ? port_a_i : cap_a; // R3 R4
  assign wr_b     = (WR_EDGE == DPW_WR_RISE) ? port_b_i : cap_b; // R3 R4
  assign wr_en_a  = !READ_ONLY && wr_a.we; // R10
  assign wr_en_b  = !READ_ONLY && wr_b.we; // R10
  assign wr_clash = !READ_ONLY && clash(wr_a, wr_b); // R7

  // ==========================================================================
  // Array update on the chosen edge.
  // The unknown marker stands in for contended contents; the stored bits
  // are then whatever port B left, and must not be trusted.
  generate
    if (WR_EDGE == DPW_WR_RISE) begin : g_rise
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          for (int i = 0; i < DEPTH; i++) bad_r[i] <= BAD_RST;
        end else begin
          if (wr_en_a) bad_r[wr_a.addr] <= wr_clash; // R7 R8
          if (wr_en_b) bad_r[wr_b.addr] <= wr_clash; // R7 R8
        end
      end
      always_ff @(posedge clk_i) begin
        if (wr_en_a) mem[wr_a.addr] <= wr_a.data; // R3 R11
        if (wr_en_b) mem[wr_b.addr] <= wr_b.data; // R3 R11
      end
    end else begin : g_fall
      always_ff @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          for (int i = 0; i < DEPTH; i++) bad_r[i] <= BAD_RST;
        end else begin
          if (wr_en_a) bad_r[wr_a.addr] <= wr_clash; // R4 R7 R8
          if (wr_en_b) bad_r[wr_b.addr] <= wr_clash; // R4 R7 R8
        end
      end
      always_ff @(negedge clk_i) begin
        if (wr_en_a) mem[wr_a.addr] <= wr_a.data; // R4 R11
        if (wr_en_b) mem[wr_b.addr] <= wr_b.data; // R4 R11
      end
    end
  endgenerate

  // ==========================================================================
  // Read paths.
  // Continuous read is a mux from the array and so is not a flop output;
  // that is the price of seeing a write without waiting for an edge.
  dpw_rsp_s rd_a_now;
  dpw_rsp_s rd_b_now;
  dpw_rsp_s rd_a_r;
  dpw_rsp_s rd_b_r;

  assign rd_a_now = '{data: mem[port_a_i.addr], unknown: bad_r[port_a_i.addr]};
  assign rd_b_now = '{data: mem[port_b_i.addr], unknown: bad_r[port_b_i.addr]};

  // Registered read samples the array on the rising edge only.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_a_r <= '0;
      rd_b_r <= '0;
    end else begin
      rd_a_r <= rd_a_now; // R2
      rd_b_r <= rd_b_now; // R2
    end
  end

  assign rsp_a_o = RD_CONT ? rd_a_now : rd_a_r; // R1 R6
  assign rsp_b_o = RD_CONT ? rd_b_now : rd_b_r; // R1 R6

  // ==========================================================================
  // Assertions.
  // R9 is the user's duty; the checks below show what happens if broken.
  a_capture_regs: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    !rst_i ##1 1'b1
    |-> cap_a == $past(port_a_i) && cap_b == $past(port_b_i))
    else $error("Captured request differs from the last rising edge input");

  a_write_lands: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    !READ_ONLY && port_a_i.we && !clash(port_a_i, port_b_i)
    |=> mem[$past(port_a_i.addr)] == $past(port_a_i.data))
    else $error("Port A write not stored by the next rising edge");

  a_fall_delay: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    WR_EDGE == DPW_WR_FALL && !READ_ONLY && cap_a.we && !clash(cap_a, cap_b)
    |-> mem[cap_a.addr] == cap_a.data)
    else $error("Falling mode missed the half-cycle commit");

  a_clash_marks: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    !READ_ONLY && clash(port_a_i, port_b_i)
    |=> bad_r[$past(port_a_i.addr)])
    else $error("Contended word not marked unknown");

  a_clean_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    !READ_ONLY && port_b_i.we && !clash(port_a_i, port_b_i)
    |=> !bad_r[$past(port_b_i.addr)])
    else $error("Clean write left the word unknown");

  a_both_stored: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    !READ_ONLY && port_a_i.we && port_b_i.we
    && port_a_i.addr != port_b_i.addr
    |=> mem[$past(port_a_i.addr)] == $past(port_a_i.data)
     && mem[$past(port_b_i.addr)] == $past(port_b_i.data))
    else $error("Simultaneous writes to different words lost one");

  a_rom_frozen: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    READ_ONLY && clash(port_a_i, port_b_i)
    |=> !bad_r[$past(port_a_i.addr)])
    else $error("Read-only array took a contended write");

  a_reg_read: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (!RD_CONT && !rst_i) ##1 1'b1
    |-> rsp_a_o.data === $past(mem[port_a_i.addr]))
    else $error("Registered read did not follow the rising edge");

  a_cont_read: assert property (@(posedge clk_i) disable iff (rst_i) // R1 R6
    RD_CONT && !READ_ONLY && port_a_i.we && !port_b_i.we
    |=> rsp_b_o.data === mem[port_b_i.addr]
     && (port_b_i.addr != $past(port_a_i.addr)
         || rsp_b_o.data == $past(port_a_i.data)))
    else $error("Continuous read missed a completed write");

  c_clash:  cover property (@(posedge clk_i) clash(port_a_i, port_b_i));
  c_recover: cover property (@(posedge clk_i)
    clash(port_a_i, port_b_i) ##1 port_a_i.we
    && port_a_i.addr == $past(port_a_i.addr) && !port_b_i.we);
  c_dual:   cover property (@(posedge clk_i) port_a_i.we && port_b_i.we
    && port_a_i.addr != port_b_i.addr);

endmodule : dpw_ram

// ==== design/dpw_pkg.sv ====
// Shared widths, modes and carriers for the dual-port edge-selectable RAM.
// Assumes one clock for both ports and user logic that drives the ports
// synchronously to it.
package dpw_pkg;

  // ==========================================================================
  // Sizes.
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int DEPTH   = 32;

  // ==========================================================================
  // Reset values and modes.
  localparam logic CAP_WE_RST = 1'b0;
  localparam logic BAD_RST    = 1'b0;

  // Edge of the write clock on which the array itself is updated.
  typedef enum logic {
    DPW_WR_RISE,
    DPW_WR_FALL
  } dpw_edge_e;

  // One port's request: write enable, address and write data.
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dpw_req_s;

  // One port's answer: read word and its unknown marker.
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              unknown;
  } dpw_rsp_s;

endpackage : dpw_pkg

// ==== design/dpw_cap.sv ====
// Input capture stage of one RAM port: write enable, address and data.
// Assumes the request is stable around the rising clock edge.
`timescale 1ns/100ps
module dpw_cap (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire dpw_pkg::dpw_req_s req_i,
  output logic                   we_o,
  output dpw_pkg::dpw_req_s      cap_o
);
  import dpw_pkg::*;

  // ==========================================================================
  // Capture.
  // The request is always latched on the rising edge, whichever edge later
  // commits it, so both write styles see identical setup windows.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_o <= '0;
    end else begin
      cap_o <= req_i; // R5
    end
  end

  assign we_o = cap_o.we;

endmodule : dpw_cap

// ==== tb/dpw_user.sv ====
// Behavioural user logic that drives one RAM port request.
// Assumes a free-running clk_i; requests change just after a rising edge.
`timescale 1ns/100ps
module dpw_user (
  input  wire logic         clk_i,
  output dpw_pkg::dpw_req_s req_o
);
  import dpw_pkg::*;

  // ==========================================================================
  // Request driver.
  initial req_o = '0;

  // One request per edge, so clashes happen only when the bench asks.
  // An idle data bus shows the inverse of its last value, so stale data
  // never looks valid.
  task automatic put(input logic              we,
                     input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    req_o <= '{we: we, addr: a, data: we ? d : ~req_o.data};
  endtask : put

endmodule : dpw_user

// ==== tb/dpw_ram_test.sv ====
// Self-checking bench for the dual-port RAM in both write-edge styles.
// Assumes the port models in dpw_user and a 25 MHz clock.
`timescale 1ns/100ps
module dpw_ram_test;
  import dpw_pkg::*;

  // ==========================================================================
  // Signals and table rows.
  typedef struct packed {
    dpw_req_s a;
    dpw_req_s b;
    dpw_rsp_s ea;
    dpw_rsp_s eb;
  } dpw_row_s;
  logic     clk_i;
  logic     rst_i;
  dpw_req_s port_a;
  dpw_req_s port_b;
  dpw_rsp_s rsp_a;
  dpw_rsp_s rsp_b;
  dpw_rsp_s fall_a;
  dpw_rsp_s fall_b;
  dpw_rsp_s rom_a;
  int       n_fail;
  int       checks;
  dpw_row_s rows[5];

  // ==========================================================================
  // Port models and the two styles under test, fed by the same requests.
  dpw_user ua (.clk_i(clk_i), .req_o(port_a));
  dpw_user ub (.clk_i(clk_i), .req_o(port_b));
  dpw_ram DUT (.clk_i(clk_i), .rst_i(rst_i), .port_a_i(port_a),
    .port_b_i(port_b), .rsp_a_o(rsp_a), .rsp_b_o(rsp_b));
  dpw_ram #(.WR_EDGE(DPW_WR_FALL), .RD_CONT(1'b0)) DUT_F (.clk_i(clk_i),
    .rst_i(rst_i), .port_a_i(port_a), .port_b_i(port_b),
    .rsp_a_o(fall_a), .rsp_b_o(fall_b));
  dpw_ram #(.READ_ONLY(1'b1)) DUT_R (.clk_i(clk_i), .rst_i(rst_i),
    .port_a_i(port_a), .port_b_i(port_b), .rsp_a_o(rom_a), .rsp_b_o());

  // Free-running 40 ns clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Compare and verdict.
  task automatic chk(input string nm, input dpw_rsp_s e, input dpw_rsp_s g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_flag(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask : chk_flag

  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Tests need 33 cycles; 400 leaves ample margin for a hang.
  initial begin
    repeat (400) @(posedge clk_i);
    n_fail++;
    $display("unexpected watchdog: expected done, seen timeout");
    close_out();
  end

  // ==========================================================================
  // Main sequence. A clash row expects port B's data with the marker set.
  initial begin
    rst_i  = 1'b1;
    n_fail = 0;
    checks = 0;
    rows[0] = '{'{1'b1, 5'h01, 8'h03}, '{1'b1, 5'h02, 8'h0A}, 9'h006, 9'h014};
    rows[1] = '{'{1'b0, 5'h02, 8'h00}, '{1'b0, 5'h01, 8'h00}, 9'h014, 9'h006};
    rows[2] = '{'{1'b1, 5'h01, 8'h03}, '{1'b1, 5'h01, 8'h05}, 9'h00B, 9'h00B};
    rows[3] = '{'{1'b1, 5'h01, 8'h04}, '{1'b0, 5'h01, 8'h00}, 9'h008, 9'h008};
    rows[4] = '{'{1'b1, 5'h1F, 8'hFF}, '{1'b1, 5'h00, 8'h00}, 9'h1FE, 9'h000};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      fork
        ua.put(rows[i].a.we, rows[i].a.addr, rows[i].a.data);
        ub.put(rows[i].b.we, rows[i].b.addr, rows[i].b.data);
      join
      @(posedge clk_i);
      #1;
      chk("rsp_a", rows[i].ea, rsp_a);
      chk("rsp_b", rows[i].eb, rsp_b);
    end
    $display("test table rows done");
    // A new read address shows its word with no further edge.
    ua.put(1'b0, 5'h02, 8'h00);
    #1;
    chk("rsp_a", 9'h014, rsp_a);
    $display("test continuous read done");
    // Falling style: registered read lags until the commit has landed.
    fork
      ua.put(1'b1, 5'h01, 8'h5A);
      ub.put(1'b0, 5'h01, 8'h00);
    join
    @(posedge clk_i);
    #1;
    chk("rsp_a", 9'h0B4, rsp_a);
    chk("fall_a", 9'h008, fall_a);
    @(posedge clk_i);
    #1;
    chk("fall_b", 9'h0B4, fall_b);
    $display("test falling write done");
    // A clash marks the word; the read-only build keeps no such mark.
    fork
      ua.put(1'b1, 5'h03, 8'h11);
      ub.put(1'b1, 5'h03, 8'h22);
    join
    @(posedge clk_i);
    #1;
    chk("rsp_a", 9'h045, rsp_a);
    chk_flag("rom_a", 1'b0, rom_a.unknown);
    // Mid-run reset clears registered outputs and the clash mark at once.
    fork
      ua.put(1'b0, 5'h03, 8'h00);
      ub.put(1'b0, 5'h03, 8'h00);
    join
    rst_i <= 1'b1;
    #1;
    chk("fall_a", 9'h000, fall_a);
    chk("rsp_a", 9'h044, rsp_a);
    @(posedge clk_i);
    rst_i <= 1'b0;
    // The first write after release lands in both styles.
    fork
      ua.put(1'b1, 5'h04, 8'h33);
      ub.put(1'b0, 5'h04, 8'h00);
    join
    @(posedge clk_i);
    #1;
    chk("rsp_a", 9'h066, rsp_a);
    @(posedge clk_i);
    #1;
    chk("fall_b", 9'h066, fall_b);
    $display("test reset done");
    close_out();
  end

endmodule : dpw_ram_test
